// ---- hdl/timing_pin_pkg.sv ----
// Constants and carriers for the connector timing-pin block.
// Assumes one 20 MHz clock; all pin inputs already synchronous.
// Behaviour
// (RQ1) One scan pulse per conversion when enabled
// (RQ2) Scan pulse rises when input may switch
// (RQ3) Strobe level changes only by software
// (RQ4) Pin 0 input: function input or trigger
// (RQ5) Pin 0 output: acquisition start trigger
// (RQ6) Pin 1 output: posttrigger start trigger
// (RQ7) Pin 2 output: active-low conversion pulse
// (RQ8) Pins 3, 8 copy counter sources
// (RQ9) Pins 4, 9 copy counter gates
// (RQ10) Dedicated pins carry both counter outputs
// (RQ11) Pin 5 output: active-low update pulse
// (RQ12) Pin 6 output: waveform start trigger
// (RQ13) Pin 7 pulses at each scan start
// (RQ14) Frequency pin carries generator output
// (RQ15) Every input pin selectable routing source
// (RQ16) I/O lines 6, 7 drive count direction
// (RQ17) Each pin driver enabled individually
// (RQ18) Pins shared by several timing signals
// (RQ19) Direction tap input-only, I/O unaffected
// (RQ20) I/O lines high impedance after reset
// (RQ21) Pin drivers disabled after reset
// (RQ22) Per-line direction bit gates output
package timing_pin_pkg;
    // ========================================
    // Sizes
    localparam int PIN_COUNT   = 10;
    localparam int IO_COUNT    = 8;
    localparam int ROUTE_COUNT = 13;
    localparam int SEL_W       = 4;
    // ========================================
    // Register map (word addresses)
    localparam logic [3:0] ADDR_PIN_OE   = 4'h0;
    localparam logic [3:0] ADDR_IO_DIR   = 4'h1;
    localparam logic [3:0] ADDR_IO_OUT   = 4'h2;
    localparam logic [3:0] ADDR_IO_IN    = 4'h3;
    localparam logic [3:0] ADDR_STROBE   = 4'h4;
    localparam logic [3:0] ADDR_CTRL     = 4'h5;
    localparam logic [3:0] ADDR_PIN_IN   = 4'h6;
    localparam logic [3:0] ADDR_ROUTE0   = 4'h8;
    localparam logic [3:0] ADDR_ROUTE1   = 4'h9;
    // ========================================
    // Field positions and reset values
    localparam int CTRL_SCAN_EN_BIT   = 0;
    localparam int CTRL_ANA_TRIG_BIT  = 1;
    localparam int IO_UPDOWN_A_BIT    = 6;
    localparam int IO_UPDOWN_B_BIT    = 7;
    localparam logic [9:0] PIN_OE_RST = 10'h000;
    localparam logic [7:0] IO_DIR_RST = 8'h00;
    localparam logic [7:0] IO_OUT_RST = 8'h00;
    localparam logic       STROBE_RST = 1'b1;
    localparam logic [3:0] SEL_NONE   = 4'hf;

    // Internal timing signals presented to the pins
    typedef struct packed {
        logic acq_trig;
        logic post_trig;
        logic convert_n;
        logic ctr_b_src;
        logic ctr_b_gate;
        logic update_n;
        logic wave_trig;
        logic scan_start;
        logic ctr_a_src;
        logic ctr_a_gate;
    } timing_out_s;

    // Dedicated outputs
    typedef struct packed {
        logic counter_a_output;
        logic counter_b_output;
        logic frequency_generator_output;
        logic per_conversion_pulse;
        logic software_toggled_strobe_n;
    } dedicated_s;
endpackage

// ---- hdl/route_select.sv ----
// One routing multiplexer choosing a function pin for a timing signal.
// Assumes pin levels already synchronous; output registered.
`timescale 1ns/1ps
module route_select #(
    parameter int PINS = 10
) (
    input  wire logic             core_clk_i,
    input  wire logic             reset_i,
    input  wire logic [PINS-1:0]  pins_i,
    input  wire logic [3:0]       sel_i,
    output logic                  route_o
);
    logic route_d;
    logic route_q;

    // ========================================
    // Selection; out-of-range codes give low
    always_comb begin
        route_d = 1'b0;
        if (int'(sel_i) < PINS) begin
            route_d = pins_i[sel_i];
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            route_q <= 1'b0;
        end else begin
            route_q <= route_d;
        end
    end

    assign route_o = route_q;
endmodule

// ---- hdl/io_line.sv ----
// One general I/O line: direction bit, output latch, tri-state split.
// Assumes pin input synchronous; pad resolved outside.
`timescale 1ns/1ps
module io_line (
    input  wire logic core_clk_i,
    input  wire logic reset_i,
    input  wire logic dir_i,
    input  wire logic val_i,
    input  wire logic pin_i,
    output logic      pin_o,
    output logic      pin_oe_o,
    output logic      in_o
);
    logic oe_d, oe_q, out_d, out_q, in_d, in_q;

    // ========================================
    // Value reaches pad only while an output
    always_comb begin
        oe_d  = dir_i;  // RQ22
        out_d = val_i;
        in_d  = pin_i;
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            oe_q  <= 1'b0;  // RQ20
            out_q <= 1'b0;
            in_q  <= 1'b0;
        end else begin
            oe_q  <= oe_d;
            out_q <= out_d;
            in_q  <= in_d;
        end
    end

    assign pin_o    = out_q;
    assign pin_oe_o = oe_q;
    assign in_o     = in_q;
endmodule

// ---- hdl/timing_pin_interface.sv ----
// Connector timing pins: function pin mux, counter and strobe pins,
// general I/O lines and a small register port.
// Assumes internal timing signals come synchronous from the timing core.
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ps
module timing_pin_interface #(
    parameter int PINS   = timing_pin_pkg::PIN_COUNT,
    parameter int IOS    = timing_pin_pkg::IO_COUNT,
    parameter int ROUTES = timing_pin_pkg::ROUTE_COUNT
) (
    input  wire logic                         core_clk_i,
    input  wire logic                         reset_i,
    // Register port
    input  wire logic [3:0]                   reg_addr_i,
    input  wire logic [31:0]                  reg_wdata_i,
    input  wire logic                         reg_write_i,
    input  wire logic                         reg_read_i,
    output logic [31:0]                       reg_rdata_o,
    // Internal timing signals from the timing core
    input  wire timing_pin_pkg::timing_out_s  timing_i,
    input  wire logic                         conversion_start_i,
    input  wire logic                         input_switch_ok_i,
    input  wire logic                         scanning_i,
    input  wire logic                         counter_a_output_i,
    input  wire logic                         counter_b_output_i,
    input  wire logic                         freq_gen_i,
    // Function pins
    input  wire logic [PINS-1:0]              programmable_function_pin_i,
    output logic [PINS-1:0]                   programmable_function_pin_o,
    output logic [PINS-1:0]                   programmable_function_pin_oe_o,
    // Routed external sources for the timing core
    output logic [ROUTES-1:0]                 route_src_o,
    output logic                              analog_trigger_src_o,
    // Dedicated outputs
    output timing_pin_pkg::dedicated_s        dedicated_o,
    // General I/O lines
    input  wire logic [IOS-1:0]               general_io_line_i,
    output logic [IOS-1:0]                    general_io_line_o,
    output logic [IOS-1:0]                    general_io_line_oe_o,
    output logic                              counter_a_up_o,
    output logic                              counter_b_up_o
);
    // ========================================
    // Configuration registers
    logic [PINS-1:0]       pin_oe_d, pin_oe_q;
    logic [IOS-1:0]        io_dir_d, io_dir_q;
    logic [IOS-1:0]        io_out_d, io_out_q;
    logic                  strobe_d, strobe_q;
    logic                  scan_en_d, scan_en_q;
    logic                  ana_trig_d, ana_trig_q;
    logic [ROUTES*4-1:0]   sel_d, sel_q;
    logic [31:0]           rdata_d, rdata_q;
    logic [IOS-1:0]        io_in;
    logic [ROUTES-1:0]     route_w;

    // Register writes and read mux
    always_comb begin
        pin_oe_d   = pin_oe_q;
        io_dir_d   = io_dir_q;
        io_out_d   = io_out_q;
        strobe_d   = strobe_q;
        scan_en_d  = scan_en_q;
        ana_trig_d = ana_trig_q;
        sel_d      = sel_q;
        rdata_d    = 32'h0000_0000;
        if (reg_write_i) begin
            unique case (reg_addr_i)
                timing_pin_pkg::ADDR_PIN_OE:
                    pin_oe_d = reg_wdata_i[PINS-1:0];  // RQ17
                timing_pin_pkg::ADDR_IO_DIR:
                    io_dir_d = reg_wdata_i[IOS-1:0];  // RQ22
                timing_pin_pkg::ADDR_IO_OUT:
                    io_out_d = reg_wdata_i[IOS-1:0];
                timing_pin_pkg::ADDR_STROBE:
                    strobe_d = reg_wdata_i[0];  // RQ3
                timing_pin_pkg::ADDR_CTRL: begin
                    scan_en_d  = reg_wdata_i[timing_pin_pkg::CTRL_SCAN_EN_BIT];
                    ana_trig_d = reg_wdata_i[
                        timing_pin_pkg::CTRL_ANA_TRIG_BIT];
                end
                timing_pin_pkg::ADDR_ROUTE0:
                    sel_d[31:0] = reg_wdata_i;  // RQ18
                timing_pin_pkg::ADDR_ROUTE1:
                    sel_d[ROUTES*4-1:32] = reg_wdata_i[ROUTES*4-33:0];
                default: ;
            endcase
        end
        if (reg_read_i) begin
            unique case (reg_addr_i)
                timing_pin_pkg::ADDR_PIN_OE:
                    rdata_d[PINS-1:0] = pin_oe_q;
                timing_pin_pkg::ADDR_IO_DIR:
                    rdata_d[IOS-1:0] = io_dir_q;
                timing_pin_pkg::ADDR_IO_OUT:
                    rdata_d[IOS-1:0] = io_out_q;
                timing_pin_pkg::ADDR_IO_IN:
                    rdata_d[IOS-1:0] = io_in;
                timing_pin_pkg::ADDR_STROBE:
                    rdata_d[0] = strobe_q;
                timing_pin_pkg::ADDR_CTRL: begin
                    rdata_d[timing_pin_pkg::CTRL_SCAN_EN_BIT]  = scan_en_q;
                    rdata_d[timing_pin_pkg::CTRL_ANA_TRIG_BIT] = ana_trig_q;
                end
                timing_pin_pkg::ADDR_PIN_IN:
                    rdata_d[PINS-1:0] = programmable_function_pin_i;
                timing_pin_pkg::ADDR_ROUTE0:
                    rdata_d = sel_q[31:0];
                timing_pin_pkg::ADDR_ROUTE1:
                    rdata_d[ROUTES*4-33:0] = sel_q[ROUTES*4-1:32];
                default: rdata_d = 32'h0000_0000;  // Unmapped reads zero
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            pin_oe_q   <= timing_pin_pkg::PIN_OE_RST;  // RQ21
            io_dir_q   <= timing_pin_pkg::IO_DIR_RST;  // RQ20
            io_out_q   <= timing_pin_pkg::IO_OUT_RST;
            strobe_q   <= timing_pin_pkg::STROBE_RST;
            scan_en_q  <= 1'b0;
            ana_trig_q <= 1'b0;
            sel_q      <= {ROUTES{timing_pin_pkg::SEL_NONE}};
            rdata_q    <= 32'h0000_0000;
        end else begin
            pin_oe_q   <= pin_oe_d;
            io_dir_q   <= io_dir_d;
            io_out_q   <= io_out_d;
            strobe_q   <= strobe_d;
            scan_en_q  <= scan_en_d;
            ana_trig_q <= ana_trig_d;
            sel_q      <= sel_d;
            rdata_q    <= rdata_d;
        end
    end

    assign reg_rdata_o = rdata_q;

    // ========================================
    // Routing: each timing signal picks any pin, pins may be shared
    for (genvar r = 0; r < ROUTES; r++) begin : g_route
        route_select #(
            .PINS (PINS)
        ) u_sel (
            .core_clk_i (core_clk_i),
            .reset_i    (reset_i),
            .pins_i     (programmable_function_pin_i),  // RQ15
            .sel_i      (sel_q[r*4 +: 4]),
            .route_o    (route_w[r])
        );
    end
    assign route_src_o = route_w;

    // ========================================
    // Pin drive and dedicated outputs, all registered
    logic [PINS-1:0] pin_d, pin_q, pin_en_q;
    logic            ana_d, ana_q;
    timing_pin_pkg::dedicated_s ded_d, ded_q;
    logic            up_a_q, up_b_q;

    always_comb begin
        pin_d[0] = timing_i.acq_trig;    // RQ5
        pin_d[1] = timing_i.post_trig;   // RQ6
        pin_d[2] = timing_i.convert_n;   // RQ7
        pin_d[3] = timing_i.ctr_b_src;   // RQ8
        pin_d[4] = timing_i.ctr_b_gate;  // RQ9
        pin_d[5] = timing_i.update_n;    // RQ11
        pin_d[6] = timing_i.wave_trig;   // RQ12
        pin_d[7] = timing_i.scan_start;  // RQ13
        pin_d[8] = timing_i.ctr_a_src;   // RQ8
        pin_d[9] = timing_i.ctr_a_gate;  // RQ9
        // Pin 0 as analog trigger source only when chosen
        ana_d = ana_trig_q & programmable_function_pin_i[0];  // RQ4
        ded_d.counter_a_output = counter_a_output_i;  // RQ10
        ded_d.counter_b_output = counter_b_output_i;  // RQ10
        ded_d.frequency_generator_output = freq_gen_i;  // RQ14
        // Rises once the input may switch, falls as the conversion ends
        ded_d.per_conversion_pulse = scan_en_q & scanning_i
            & conversion_start_i & input_switch_ok_i;  // RQ1 RQ2
        ded_d.software_toggled_strobe_n = strobe_q;  // RQ3
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            pin_q    <= '0;
            pin_en_q <= '0;  // RQ21
            ana_q    <= 1'b0;
            // Strobe pin idles high so reset gives no false strobe edge
            ded_q    <= '{
                software_toggled_strobe_n: timing_pin_pkg::STROBE_RST,
                default: 1'b0};  // RQ3
            up_a_q   <= 1'b0;
            up_b_q   <= 1'b0;
        end else begin
            pin_q    <= pin_d;
            pin_en_q <= pin_oe_q;  // RQ17
            ana_q    <= ana_d;
            ded_q    <= ded_d;
            // Tap reads pad only, never drives it
            up_a_q   <= general_io_line_i[
                timing_pin_pkg::IO_UPDOWN_A_BIT];  // RQ16 RQ19
            up_b_q   <= general_io_line_i[
                timing_pin_pkg::IO_UPDOWN_B_BIT];  // RQ16 RQ19
        end
    end

    assign programmable_function_pin_o    = pin_q;
    assign programmable_function_pin_oe_o = pin_en_q;
    assign analog_trigger_src_o           = ana_q;
    assign dedicated_o                    = ded_q;
    assign counter_a_up_o                 = up_a_q;
    assign counter_b_up_o                 = up_b_q;

    // ========================================
    // General I/O lines
    for (genvar i = 0; i < IOS; i++) begin : g_io
        io_line u_io (
            .core_clk_i (core_clk_i),
            .reset_i    (reset_i),
            .dir_i      (io_dir_q[i]),
            .val_i      (io_out_q[i]),
            .pin_i      (general_io_line_i[i]),
            .pin_o      (general_io_line_o[i]),
            .pin_oe_o   (general_io_line_oe_o[i]),
            .in_o       (io_in[i])
        );
    end
endmodule

// ---- test/timing_pin_monitor.sv ----
// Checker for the connector timing-pin block, watching top ports only.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module timing_pin_monitor #(
    parameter int PINS   = 10,
    parameter int IOS    = 8,
    parameter int ROUTES = 13
) (
    input wire logic                        core_clk_i,
    input wire logic                        reset_i,
    input wire logic [3:0]                  reg_addr_i,
    input wire logic [31:0]                 reg_wdata_i,
    input wire logic                        reg_write_i,
    input wire timing_pin_pkg::timing_out_s timing_i,
    input wire logic                        conversion_start_i,
    input wire logic                        input_switch_ok_i,
    input wire logic                        scanning_i,
    input wire logic                        counter_a_output_i,
    input wire logic                        counter_b_output_i,
    input wire logic                        freq_gen_i,
    input wire logic [PINS-1:0]             programmable_function_pin_i,
    input wire logic [PINS-1:0]             programmable_function_pin_o,
    input wire logic [PINS-1:0]             programmable_function_pin_oe_o,
    input wire logic                        analog_trigger_src_o,
    input wire timing_pin_pkg::dedicated_s  dedicated_o,
    input wire logic [IOS-1:0]              general_io_line_i,
    input wire logic [IOS-1:0]              general_io_line_oe_o,
    input wire logic                        counter_a_up_o,
    input wire logic                        counter_b_up_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    // ========
    // Helpers: pin n shows struct field n, so the struct is reversed
    logic [PINS-1:0] rev;
    logic            oe_wr;
    logic            stb_wr;
    assign rev = {<<{timing_i}};
    assign oe_wr = reg_write_i && reg_addr_i == 4'h0;
    assign stb_wr = reg_write_i && reg_addr_i == 4'h4;
    // ========
    // Pin copies: the first edge after release still holds reset zeros
    pin_copy_a: assert property (
        $past(!reset_i) |-> programmable_function_pin_o == $past(rev))
        else $error("function pin copy wrong");
    ctr_out_a: assert property (
        $past(!reset_i) |-> dedicated_o[4:3] ==
            $past({counter_a_output_i, counter_b_output_i}))
        else $error("counter output pins wrong");
    frequency_generator_output_a: assert property (
        $past(!reset_i) |->
            dedicated_o.frequency_generator_output == $past(freq_gen_i))
        else $error("frequency pin wrong");
    scan_pulse_a: assert property (
        dedicated_o.per_conversion_pulse |-> $past(scanning_i
            && conversion_start_i && input_switch_ok_i))
        else $error("scan pulse without conversion");
    strobe_sw_a: assert property (
        $changed(dedicated_o.software_toggled_strobe_n) |->
            $past(stb_wr, 1) || $past(stb_wr, 2))
        else $error("strobe moved without a write");
    ana_trig_a: assert property (
        analog_trigger_src_o |-> $past(programmable_function_pin_i[0]))
        else $error("analog trigger without pin level");
    pin_oe_a: assert property (
        oe_wr ##1 !oe_wr |-> ##1
            programmable_function_pin_oe_o == $past(reg_wdata_i[PINS-1:0], 2))
        else $error("pin drivers not as written");
    reset_off_a: assert property (
        $fell(reset_i) |-> programmable_function_pin_oe_o == '0
            && general_io_line_oe_o == '0)
        else $error("drivers on after reset");
    updown_a: assert property (
        $stable(general_io_line_i[7:6])[*3] |->
            {counter_b_up_o, counter_a_up_o} == general_io_line_i[7:6])
        else $error("count direction not from io lines");
endmodule

bind timing_pin_interface timing_pin_monitor #(
    .PINS(PINS), .IOS(IOS), .ROUTES(ROUTES)
) mon (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
    .timing_i(timing_i), .conversion_start_i(conversion_start_i),
    .input_switch_ok_i(input_switch_ok_i), .scanning_i(scanning_i),
    .counter_a_output_i(counter_a_output_i),
    .counter_b_output_i(counter_b_output_i), .freq_gen_i(freq_gen_i),
    .programmable_function_pin_i(programmable_function_pin_i),
    .programmable_function_pin_o(programmable_function_pin_o),
    .programmable_function_pin_oe_o(programmable_function_pin_oe_o),
    .analog_trigger_src_o(analog_trigger_src_o), .dedicated_o(dedicated_o),
    .general_io_line_i(general_io_line_i),
    .general_io_line_oe_o(general_io_line_oe_o),
    .counter_a_up_o(counter_a_up_o), .counter_b_up_o(counter_b_up_o));

// ---- test/connector_model.sv ----
// Far-side model: instruments that drive or release connector pins.
// Assumes the bench sets drive enables and values after clock edges.
`timescale 1ns/1ps
module connector_model (
    input  wire logic       core_clk_i,
    input  wire logic [9:0] pin_en_i,
    input  wire logic [9:0] pin_val_i,
    input  wire logic [9:0] dev_pin_i,
    input  wire logic [9:0] dev_pin_oe_i,
    input  wire logic [7:0] io_en_i,
    input  wire logic [7:0] io_val_i,
    input  wire logic [7:0] dev_io_i,
    input  wire logic [7:0] dev_io_oe_i,
    output logic      [9:0] pin_o,
    output logic      [7:0] io_o
);
    // ========
    // Lines 6, 7 are pulled both ways, so a released level is undefined:
    // show one that flips every cycle
    logic [1:0] float_q = 2'b01;
    always_ff @(posedge core_clk_i) begin
        float_q <= ~float_q;
    end
    // Device driver wins; released function pins pull up
    assign pin_o = (dev_pin_oe_i & dev_pin_i)
        | (~dev_pin_oe_i & (~pin_en_i | pin_val_i));
    assign io_o = (dev_io_oe_i & dev_io_i) | (~dev_io_oe_i
        & ((io_en_i & io_val_i) | (~io_en_i & {float_q, 6'h3f})));
endmodule

// ---- test/tb_timing_pin_interface.sv ----
// Random and corner-case bench for the connector timing-pin block.
// Assumes package, checker and connector model are compiled first.
`timescale 1ns/1ps
module tb_timing_pin_interface;
    logic        core_clk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] seed = 32'hdf99ee77;
    logic [31:0] rd;
    logic [31:0] rdata;
    logic        wr = 1'b0;
    logic        rd_s = 1'b0;
    logic [5:0]  misc = 6'h0; // conv, switch ok, scanning, ctr a, b, freq
    logic [9:0]  pen = 10'h0;
    logic [9:0]  pval = 10'h0;
    logic [7:0]  ien = 8'h0;
    logic [7:0]  ival = 8'h0;
    logic [9:0]  pin, pin_o, pin_oe;
    logic [7:0]  io, io_o, io_oe;
    logic [12:0] route;
    logic        atrig, up_a, up_b;
    int          n_errors = 0;
    int          total_checks = 0;
    timing_pin_pkg::timing_out_s tim = '0;
    timing_pin_pkg::dedicated_s  ded;

    always #25 core_clk_i = ~core_clk_i;

    timing_pin_interface dut (
        .core_clk_i(core_clk_i), .reset_i(reset_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_write_i(wr), .reg_read_i(rd_s),
        .reg_rdata_o(rdata), .timing_i(tim), .conversion_start_i(misc[5]),
        .input_switch_ok_i(misc[4]), .scanning_i(misc[3]),
        .counter_a_output_i(misc[2]), .counter_b_output_i(misc[1]),
        .freq_gen_i(misc[0]), .programmable_function_pin_i(pin),
        .programmable_function_pin_o(pin_o),
        .programmable_function_pin_oe_o(pin_oe), .route_src_o(route),
        .analog_trigger_src_o(atrig), .dedicated_o(ded),
        .general_io_line_i(io), .general_io_line_o(io_o),
        .general_io_line_oe_o(io_oe), .counter_a_up_o(up_a),
        .counter_b_up_o(up_b));
    connector_model far (
        .core_clk_i(core_clk_i), .pin_en_i(pen), .pin_val_i(pval),
        .dev_pin_i(pin_o), .dev_pin_oe_i(pin_oe), .io_en_i(ien),
        .io_val_i(ival), .dev_io_i(io_o), .dev_io_oe_i(io_oe),
        .pin_o(pin), .io_o(io));

    // ========
    // Helpers: random source, expectations, bus cycles
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    function automatic logic [9:0] rv(logic [9:0] x);
        return {<<{x}};
    endfunction
    function automatic logic [12:0] exp_route(logic [51:0] s, logic [9:0] p);
        for (int r = 0; r < 13; r++) begin
            exp_route[r] = s[4*r +: 4] > 4'h9 ? 1'b0 : p[s[4*r +: 4]];
        end
    endfunction
    task automatic chk(string nm, logic [31:0] e, logic [31:0] got);
        total_checks++;
        if (got !== e) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, got);
        end
    endtask
    task automatic wr_reg(logic [3:0] a, logic [31:0] d);
        @(posedge core_clk_i);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge core_clk_i);
        wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(logic [3:0] a);
        @(posedge core_clk_i);
        rd_s <= 1'b1;
        addr <= a;
        @(posedge core_clk_i);
        rd_s <= 1'b0;
        @(negedge core_clk_i);
        rd = rdata;
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge core_clk_i);
        @(negedge core_clk_i);
    endtask
    // Address 7 is unmapped and must read zero
    task automatic reset_and_check();
        logic [3:0]  a [8];
        logic [31:0] e [8];
        a = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h7, 4'h8, 4'h9};
        e = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h0, 32'h0, 32'hffffffff,
              32'h000fffff};
        repeat (4) @(posedge core_clk_i);
        reset_i <= 1'b0;
        @(negedge core_clk_i);
        chk("pin oe", 32'h0, pin_oe);
        chk("io oe", 32'h0, io_oe);
        chk("strobe pin", 32'h1, ded.software_toggled_strobe_n);
        for (int k = 0; k < 8; k++) begin
            rd_reg(a[k]);
            chk("reset reg", e[k], rd);
        end
        $display("test reset done");
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ========
    // Watchdog: the run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge core_clk_i);
        n_errors++;
        close_out();
    end

    // ========
    // Main sequence
    initial begin
        logic [31:0] v;
        logic [51:0] s;
        logic [9:0]  e;
        logic [7:0]  d;
        logic [7:0]  lvl;
        reset_and_check();
        for (int i = 0; i < 20; i++) begin
            v = rnd();
            wr_reg(4'h0, {22'h0, v[9:0]});
            @(posedge core_clk_i);
            tim <= v[19:10];
            misc[2:0] <= v[22:20];
            tick(1);
            e = rv(v[19:10]);
            chk("pins", e, pin_o);
            chk("pin oe", v[9:0], pin_oe);
            chk("ctr out", v[22:21], ded[4:3]);
            chk("freq", v[20], ded.frequency_generator_output);
        end
        $display("test pins done");
        // Thirteen selects over ten pins, codes above 9 set to none, so pins are shared only by chance
        wr_reg(4'h0, 32'h0);
        for (int i = 0; i < 4; i++) begin
            for (int r = 0; r < 13; r++) begin
                v = rnd();
                s[4*r +: 4] = v[3:0] > 4'h9 ? 4'hf : v[3:0];
            end
            wr_reg(4'h8, s[31:0]);
            wr_reg(4'h9, {12'h0, s[51:32]});
            @(posedge core_clk_i);
            pen <= 10'h3ff;
            pval <= v[13:4];
            tick(3);
            chk("routes", exp_route(s, v[13:4]), route);
            rd_reg(4'h6);
            chk("pin in", v[13:4], rd);
        end
        wr_reg(4'h5, 32'h2);
        for (int b = 0; b < 2; b++) begin
            @(posedge core_clk_i);
            pval[0] <= b[0];
            tick(2);
            chk("ana trig", b, atrig);
        end
        wr_reg(4'h5, 32'h1);
        tick(2);
        chk("ana trig off", 32'h0, atrig);
        // Scan pulse enabled for twenty two-cycle samples, then disabled
        for (int i = 0; i < 40; i++) begin
            if (i == 20) wr_reg(4'h5, 32'h0);
            v = rnd();
            @(posedge core_clk_i);
            misc[5:3] <= v[2:0];
            tick(1);
            e = (i < 20) & v[2] & v[1] & v[0];
            chk("scan", e, ded.per_conversion_pulse);
        end
        for (int b = 0; b < 4; b++) begin
            wr_reg(4'h4, {31'h0, b[0]});
            tick(2);
            chk("strobe", b[0], ded.software_toggled_strobe_n);
        end
        $display("test timing done");
        for (int i = 0; i < 8; i++) begin
            v = rnd();
            d = v[7:0];
            wr_reg(4'h1, {24'h0, d});
            wr_reg(4'h2, {24'h0, v[15:8]});
            @(posedge core_clk_i);
            ien <= ~d;
            ival <= v[23:16];
            tick(3);
            lvl = (d & v[15:8]) | (~d & v[23:16]);
            chk("io oe", d, io_oe);
            chk("io out", d & v[15:8], io_o & io_oe);
            chk("up down", lvl[7:6], {up_b, up_a});
            rd_reg(4'h3);
            chk("io in", lvl, rd);
        end
        $display("test io done");
        // Second reset with drivers on and strobe low
        wr_reg(4'h0, 32'h3ff);
        wr_reg(4'h4, 32'h0);
        @(posedge core_clk_i);
        reset_i <= 1'b1;
        reset_and_check();
        close_out();
    end
endmodule
